// >>> hdl/sram_port_pkg.sv
// Constants and types shared by the pipelined synchronous SRAM control port
//
// Overview of operation
// - Selected only when low_a low, high high, low_b low
// - Chip selects sampled only on new address load
// - Processor strobe ignored while low_a sampled high
// - Processor strobe captures address, seeds burst counter
// - Controller strobe captures address, seeds burst counter
// - Both strobes low with low_a low: processor strobe alone acts
// - Advance low during burst steps burst address
// - Output enable low drives data, high tri-states
// - First read clock after deselect keeps outputs off
// - Sleep high halts activity, memory contents retained
// - Input data and parity registered on clock rise
// - Read data one cycle after address sample
// - Mode strap: low linear, high interleaved, static
// - Two-bit wrapping burst counter covers four locations
package sram_port_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int BURST_W = 2;
  localparam int SYNC_STAGES = 3;

  // ---------------------------------------------------------------
  // Reset value and mode encoding
  // ---------------------------------------------------------------
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic MODE_LINEAR = 1'b0;

  // Port access state
  typedef enum logic [1:0] {
    ST_DESEL = 2'b00,
    ST_FIRST = 2'b01,
    ST_ACTIVE = 2'b10
  } port_state_t;

endpackage

// >>> hdl/pin_sync.sv
// Three-stage synchroniser for an asynchronous pin with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic level_o
);

  logic [2:0] stage;
  logic [2:0] next_stage;
  logic level;
  logic next_level;

  // Shift chain; level only follows when stages two and three agree
  always_comb begin
    next_stage = {stage[1:0], pin_i};
    next_level = (stage[1] == stage[2]) ? stage[2] : level;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage <= {3{RESET_VAL}};
      level <= RESET_VAL;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign level_o = level;

endmodule
`default_nettype wire

// >>> hdl/sram_port.sv
// Control port of a pipelined synchronous burst SRAM with its memory array
`timescale 1ns/1ps
`default_nettype none
module sram_port #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W,
  parameter int DATA_W = sram_port_pkg::DATA_W,
  parameter int PAR_W = sram_port_pkg::PAR_W
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic CHIP_SELECT_LOW_A_N_I,
  input wire logic CHIP_SELECT_HIGH_I,
  input wire logic CHIP_SELECT_LOW_B_N_I,
  input wire logic PROCESSOR_ADDR_STROBE_N_I,
  input wire logic CONTROLLER_ADDR_STROBE_N_I,
  input wire logic BURST_ADVANCE_N_I,
  input wire logic WRITE_N_I,
  input wire logic OUTPUT_ENABLE_N_I,
  input wire logic SLEEP_REQUEST_I,
  input wire logic BURST_MODE_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] DATA_I,
  input wire logic [PAR_W-1:0] PARITY_LINES_I,
  output logic [DATA_W-1:0] DATA_O,
  output logic [PAR_W-1:0] PARITY_LINES_O,
  output logic DATA_OE_O,
  output logic SLEEP_O
);

  localparam int BW = sram_port_pkg::BURST_W;
  localparam int WORD_W = DATA_W + PAR_W;
  localparam int DEPTH = 1 << ADDR_W;

  // ---------------------------------------------------------------
  // Asynchronous inputs
  // ---------------------------------------------------------------

  logic sleep;
  logic mode_strap;

  // Sleep pin is asynchronous; filtered through three stages
  pin_sync #(.RESET_VAL(1'b0)) sleep_sync (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .pin_i(SLEEP_REQUEST_I),
    .level_o(sleep)
  );

  // Mode strap sampled the same way; expected static
  pin_sync #(.RESET_VAL(1'b1)) mode_sync (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .pin_i(BURST_MODE_I),
    .level_o(mode_strap)
  );

  // ---------------------------------------------------------------
  // Address load decode
  // ---------------------------------------------------------------

  logic cs_ok;
  logic proc_load;
  logic ctrl_load;
  logic load;
  logic sel_load;
  logic desel_load;
  logic burst_advance;
  logic active;

  // Strobe decode and priority
  always_comb begin
    cs_ok = !CHIP_SELECT_LOW_A_N_I && CHIP_SELECT_HIGH_I && !CHIP_SELECT_LOW_B_N_I;
    proc_load = !PROCESSOR_ADDR_STROBE_N_I && !CHIP_SELECT_LOW_A_N_I;
    ctrl_load = !CONTROLLER_ADDR_STROBE_N_I && !proc_load;
    load = (proc_load || ctrl_load) && !sleep;
    sel_load = load && cs_ok;
    desel_load = load && !cs_ok;
    burst_advance = !BURST_ADVANCE_N_I && !load && !sleep;
  end

  // ---------------------------------------------------------------
  // Address register, burst counter and access state
  // ---------------------------------------------------------------

  logic [ADDR_W-1:0] base_addr;
  logic [ADDR_W-1:0] next_base_addr;
  logic [BW-1:0] burst_cnt;
  logic [BW-1:0] next_burst_cnt;
  logic is_write;
  logic next_is_write;
  sram_port_pkg::port_state_t state;
  sram_port_pkg::port_state_t next_state;

  // Selecting loads clear the counter to BURST_RST; advance steps it
  always_comb begin
    next_base_addr = base_addr;
    next_burst_cnt = burst_cnt;
    next_is_write = is_write;
    next_state = state;
    if (sel_load) begin
      next_base_addr = ADDR_I;
      next_burst_cnt = sram_port_pkg::BURST_RST;
      next_is_write = !WRITE_N_I;
      next_state = (state == sram_port_pkg::ST_DESEL) ? sram_port_pkg::ST_FIRST
                                                      : sram_port_pkg::ST_ACTIVE;
    end else if (desel_load) begin
      next_state = sram_port_pkg::ST_DESEL;
    end else if (active) begin
      if (burst_advance) begin
        next_burst_cnt = BW'(burst_cnt + 1'b1);
      end
      if (state == sram_port_pkg::ST_FIRST && !sleep) begin
        next_state = sram_port_pkg::ST_ACTIVE;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      base_addr <= '0;
      burst_cnt <= sram_port_pkg::BURST_RST;
      is_write <= 1'b0;
      state <= sram_port_pkg::ST_DESEL;
    end else begin
      base_addr <= next_base_addr;
      burst_cnt <= next_burst_cnt;
      is_write <= next_is_write;
      state <= next_state;
    end
  end

  assign active = (state != sram_port_pkg::ST_DESEL);

  // ---------------------------------------------------------------
  // Burst address order
  // ---------------------------------------------------------------

  logic [BW-1:0] low_bits;
  logic [ADDR_W-1:0] cur_addr;

  // Linear adds the count, interleaved xors it
  always_comb begin
    if (mode_strap == sram_port_pkg::MODE_LINEAR) begin
      low_bits = BW'(base_addr[BW-1:0] + burst_cnt);
    end else begin
      low_bits = base_addr[BW-1:0] ^ burst_cnt;
    end
    cur_addr = {base_addr[ADDR_W-1:BW], low_bits};
  end

  // ---------------------------------------------------------------
  // Input data register and memory array
  // ---------------------------------------------------------------

  logic [WORD_W-1:0] din;
  logic [WORD_W-1:0] next_din;
  logic [WORD_W-1:0] mem [DEPTH];

  // Data pins registered every rise while acting as inputs
  always_comb begin
    next_din = din;
    if (!DATA_OE_O) begin
      next_din = {PARITY_LINES_I, DATA_I};
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      din <= '0;
    end else begin
      din <= next_din;
    end
  end

  // Array write of the registered word; kept through sleep
  always_ff @(posedge CORE_CLK_I) begin
    if (active && is_write && !sleep) begin
      mem[cur_addr] <= din;
    end
  end

  // ---------------------------------------------------------------
  // Output register and drive control
  // ---------------------------------------------------------------

  logic [WORD_W-1:0] dout;
  logic [WORD_W-1:0] next_dout;
  logic rd_valid;
  logic next_rd_valid;
  logic first_rd;
  logic next_first_rd;

  // Array word at the sampled address passes the output register
  always_comb begin
    next_dout = dout;
    if (active && !is_write && !sleep) begin
      next_dout = mem[cur_addr];
    end
    next_rd_valid = active && !is_write && !sleep;
    next_first_rd = (state == sram_port_pkg::ST_FIRST) && !is_write;
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      dout <= '0;
      rd_valid <= 1'b0;
      first_rd <= 1'b0;
    end else begin
      dout <= next_dout;
      rd_valid <= next_rd_valid;
      first_rd <= next_first_rd;
    end
  end

  // Output enable acts with no clock; masked on first read after deselect
  assign DATA_OE_O = !OUTPUT_ENABLE_N_I && rd_valid && !first_rd;
  assign DATA_O = dout[DATA_W-1:0];
  assign PARITY_LINES_O = dout[WORD_W-1:DATA_W];
  assign SLEEP_O = sleep;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  sel_decode_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    sel_load |-> (!CHIP_SELECT_LOW_A_N_I && CHIP_SELECT_HIGH_I && !CHIP_SELECT_LOW_B_N_I))
    else $error("select taken with inactive chip selects");

  proc_ignore_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (CHIP_SELECT_LOW_A_N_I && CONTROLLER_ADDR_STROBE_N_I) |=> $stable(base_addr))
    else $error("processor strobe acted while chip select high");

  addr_capture_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    sel_load |=> (base_addr == $past(ADDR_I)) && (burst_cnt == sram_port_pkg::BURST_RST))
    else $error("address not captured on load");

  strobe_prio_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (!PROCESSOR_ADDR_STROBE_N_I && !CONTROLLER_ADDR_STROBE_N_I && !CHIP_SELECT_LOW_A_N_I) |-> !ctrl_load)
    else $error("controller strobe acted beside processor strobe");

  burst_step_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (active && burst_advance && !desel_load) |=> (burst_cnt == 2'($past(burst_cnt) + 2'h1)))
    else $error("burst counter did not step");

  first_mask_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (state == sram_port_pkg::ST_FIRST && !is_write) |=> !DATA_OE_O)
    else $error("output driven in first read clock");

  read_pipe_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (active && !is_write && !sleep) |=> (dout == $past(mem[cur_addr])))
    else $error("read data not from sampled address");

  sleep_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    sleep |=> $stable(base_addr) && !rd_valid)
    else $error("activity while asleep");

endmodule
`default_nettype wire

// >>> bench/sram_host_model.sv
// Host-side model: resolves the shared data pins and drives the sleep pin
`timescale 1ns/1ps
`default_nettype none
module sram_host_model (
  input wire logic dev_oe_i,
  input wire logic host_oe_i,
  input wire logic sleep_req_i,
  input wire logic [31:0] dev_data_i,
  input wire logic [31:0] host_data_i,
  output logic [31:0] pin_data_o,
  output logic [3:0] pin_par_o,
  output logic sleep_o
);
  // ----------------------------------------
  // Pin resolution
  // ----------------------------------------
  // Device wins while driving; a released bus reads back inverted
  assign pin_data_o = dev_oe_i ? dev_data_i : (host_oe_i ? host_data_i : ~host_data_i);
  // Byte parity follows the resolved pins
  assign pin_par_o = {^pin_data_o[31:24], ^pin_data_o[23:16], ^pin_data_o[15:8], ^pin_data_o[7:0]};
  // Sleep raised only on request, otherwise held low
  assign sleep_o = sleep_req_i;
endmodule
`default_nettype wire

// >>> bench/test_sram_port.sv
// Self-checking bench for the synchronous SRAM control port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin error_cnt++; $display("ERROR %0t: got %h exp %h", $time, g, x); end end
module test_sram_port;
  typedef struct {int cyc; logic [31:0] data;} note_t;
  localparam logic [2:0] SEL = 3'h2;
  logic clk, rst, psn, csn, adv_n, wr_n, oe_n, sleep_req, mode, host_oe, dev_oe, slp_o, slp_pin;
  logic oe_pend, oe_exp, slp_pend, slp_exp;
  logic [2:0] cs;
  logic [9:0] addr;
  logic [31:0] hdata, pdata, dout;
  logic [3:0] ppar, dpar, epar;
  logic [31:0] mem [4];
  logic [1:0] s, b;
  note_t q[$];
  note_t e;
  int cyc, now, error_cnt, checked, seed;

  // ----------------------------------------
  // Design, host model and clock
  // ----------------------------------------
  sram_port dut (.CORE_CLK_I(clk), .RST_I(rst), .CHIP_SELECT_LOW_A_N_I(cs[2]), .CHIP_SELECT_HIGH_I(cs[1]),
    .CHIP_SELECT_LOW_B_N_I(cs[0]), .PROCESSOR_ADDR_STROBE_N_I(psn), .CONTROLLER_ADDR_STROBE_N_I(csn),
    .BURST_ADVANCE_N_I(adv_n), .WRITE_N_I(wr_n), .OUTPUT_ENABLE_N_I(oe_n), .SLEEP_REQUEST_I(slp_pin),
    .BURST_MODE_I(mode), .ADDR_I(addr), .DATA_I(pdata), .PARITY_LINES_I(ppar), .DATA_O(dout),
    .PARITY_LINES_O(dpar), .DATA_OE_O(dev_oe), .SLEEP_O(slp_o));
  sram_host_model host (.dev_oe_i(dev_oe), .host_oe_i(host_oe), .sleep_req_i(sleep_req), .dev_data_i(dout),
    .host_data_i(hdata), .pin_data_o(pdata), .pin_par_o(ppar), .sleep_o(slp_pin));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      now++;
    end
  endtask
  // Pin checks are posted here and made at the next falling edge
  task automatic chk_oe(input logic v);
    oe_exp = v;
    oe_pend = 1'h1;
  endtask
  task automatic chk_slp(input logic v);
    slp_exp = v;
    slp_pend = 1'h1;
  endtask
  // Expected read word two edges after the present one
  task automatic note(input logic [31:0] d);
    q.push_back('{now + 2, d});
  endtask
  task automatic drv(input logic [2:0] c, input logic p, input logic [9:0] a, input logic w);
    cs <= c;
    psn <= p;
    addr <= a;
    wr_n <= w;
  endtask
  // Single-location write with one hold edge
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    hdata <= d;
    drv(SEL, 1'h0, a, 1'h0);
    tick(1);
    psn <= 1'h1;
    tick(1);
  endtask
  task automatic desel();
    drv(3'h0, 1'h0, 10'h000, 1'h1);
    tick(1);
    psn <= 1'h1;
    oe_n <= 1'h1;
    chk_oe(1'h0);
    tick(1);
    chk_oe(1'h0);
  endtask

  // ----------------------------------------
  // Timeout and read monitor
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  always @(posedge clk) begin
    #1;
    if (q.size() != 0 && q[0].cyc == now) begin
      e = q.pop_front();
      epar = {^e.data[31:24], ^e.data[23:16], ^e.data[15:8], ^e.data[7:0]};
      `CHK(dout, e.data)
      `CHK(dpar, epar)
    end
  end
  // Drive enable and sleep level, settled half a period after the edge
  always @(negedge clk) begin
    if (oe_pend) begin
      `CHK(dev_oe, oe_exp)
      oe_pend = 1'h0;
    end
    if (slp_pend) begin
      `CHK(slp_o, slp_exp)
      slp_pend = 1'h0;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h9846;
    rst = 1'h1;
    cs = SEL;
    psn = 1'h1;
    csn = 1'h1;
    adv_n = 1'h1;
    wr_n = 1'h1;
    oe_n = 1'h1;
    sleep_req = 1'h0;
    mode = 1'h0;
    host_oe = 1'h1;
    hdata = 32'h0000_0000;
    addr = 10'h000;
    cyc = 0;
    now = 0;
    error_cnt = 0;
    checked = 0;
    oe_pend = 1'h0;
    slp_pend = 1'h0;
    tick(2);
    rst <= 1'h0;
    tick(4);
    // Fill one aligned line of four words
    for (int i = 0; i < 4; i++) begin
      mem[i] = $random(seed);
      wr({8'h10, i[1:0]}, mem[i]);
    end
    desel();
    // Four-beat read burst in each order, start bits off zero
    for (int m = 0; m < 2; m++) begin
      mode <= m[0];
      tick(4);
      s = m[0] ? 2'h3 : 2'h1;
      host_oe <= 1'h0;
      oe_n <= 1'h0;
      drv(SEL, 1'h0, {8'h10, s}, 1'h1);
      note(mem[s]);
      tick(1);
      psn <= 1'h1;
      for (int k = 1; k < 4; k++) begin
        b = m[0] ? (s ^ k[1:0]) : (s + k[1:0]);
        adv_n <= 1'h0;
        note(mem[b]);
        if (k == 2) drv(3'h5, 1'h0, 10'h3ff, 1'h1);
        tick(1);
        if (k == 2) psn <= 1'h1;
        chk_oe(k > 1);
      end
      // Last beat leaves the output register in the deselect cycle
      adv_n <= 1'h1;
      desel();
    end
    // Sleep refuses a write and keeps the array
    sleep_req <= 1'h1;
    tick(5);
    chk_slp(1'h1);
    host_oe <= 1'h1;
    wr({8'h10, 2'h0}, ~mem[0]);
    sleep_req <= 1'h0;
    tick(5);
    chk_slp(1'h0);
    host_oe <= 1'h0;
    oe_n <= 1'h0;
    drv(SEL, 1'h0, {8'h10, 2'h0}, 1'h1);
    note(mem[0]);
    tick(1);
    // Controller strobe alone loads a new address back to back
    psn <= 1'h1;
    csn <= 1'h0;
    addr <= {8'h10, 2'h2};
    note(mem[2]);
    tick(1);
    csn <= 1'h1;
    tick(3);
    tally_and_finish();
  end
endmodule
`default_nettype wire
